// [inc/rlam_pkg.sv]
package rlam_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int RLAM_NCH = 2;
	localparam int RLAM_DW = 16;
	localparam int RLAM_AW = 2;

	// ****************************************
	// Register map (word index)
	// ****************************************
	localparam logic [RLAM_AW-1:0] RLAM_OFS_CTRL = 2'h0;
	localparam logic [RLAM_AW-1:0] RLAM_OFS_STATUS = 2'h1;
	localparam logic [RLAM_AW-1:0] RLAM_OFS_VCNT0 = 2'h2;
	localparam logic [RLAM_AW-1:0] RLAM_OFS_VCNT1 = 2'h3;

	// Control fields
	localparam int RLAM_CTRL_CODER = 0;
	localparam int RLAM_CTRL_EXZ = 2;
	localparam int RLAM_CTRL_E1 = 4;
	localparam int RLAM_CTRL_W = 5;
	localparam logic [RLAM_CTRL_W-1:0] RLAM_CTRL_RST = 5'h00;

	// Status fields
	localparam int RLAM_STAT_AIS = 0;
	localparam int RLAM_STAT_LOS = 2;
	localparam int RLAM_STAT_ANALOG = 4;

	// ****************************************
	// Line counts and B8ZS pattern (in received bits)
	// ****************************************
	localparam logic [12:0] RLAM_AIS_LAST = 13'h1FFF;
	localparam logic [3:0] RLAM_AIS_ZEROS = 4'h9;
	localparam logic [7:0] RLAM_EXZ_AMI = 8'h10;
	localparam logic [7:0] RLAM_EXZ_B8ZS = 8'h08;
	localparam logic [7:0] RLAM_LOS_SET_RUN = 8'hAF;
	localparam logic [7:0] RLAM_LOS_CLR_LAST = 8'hAE;
	localparam logic [7:0] RLAM_LOS_CLR_ONES = 8'h16;
	localparam logic [7:0] RLAM_LOS_MAX_RUN = 8'h64;
	localparam logic [7:0] RLAM_HDB3_RUN = 8'h02;
	localparam logic [7:0] RLAM_B8ZS_PULSES = 8'h1B;
	localparam int RLAM_B8ZS_V1 = 1;
	localparam int RLAM_B8ZS_V2 = 4;

	// ****************************************
	// Sampled inputs of one channel
	// ****************************************
	localparam int RLAM_SYN_CLK = 0;
	localparam int RLAM_SYN_POS = 1;
	localparam int RLAM_SYN_NEG = 2;
	localparam int RLAM_SYN_LOSS = 3;
	localparam int RLAM_SYN_W = 4;

endpackage

// [hdl/rlam_sync2.sv]
module rlam_sync2 import rlam_pkg::*; #(
	parameter int W = RLAM_SYN_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} rlam_sync_s;

	rlam_sync_s state_r, state_nxt;

	// Two flip-flop chain, first stage read only by second
	always_comb begin
		state_nxt = state_r;
		state_nxt.meta = asyncIn;
		state_nxt.sync = state_r.meta;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign syncOut = state_r.sync;

endmodule // rlam_sync2

// [hdl/rlam_rx_front.sv]
module rlam_rx_front import rlam_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [RLAM_SYN_W-1:0] synced,
	output logic bitStb,
	output logic pulse,
	output logic polPos
);

	typedef struct packed {
		logic prevClk;
	} rlam_front_s;

	rlam_front_s state_r, state_nxt;

	// Remember receive clock level for edge detection
	always_comb begin
		state_nxt = state_r;
		state_nxt.prevClk = synced[RLAM_SYN_CLK];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Rising receive clock marks one received bit
	assign bitStb = synced[RLAM_SYN_CLK] & ~state_r.prevClk;
	assign pulse = synced[RLAM_SYN_POS] | synced[RLAM_SYN_NEG];
	assign polPos = synced[RLAM_SYN_POS];

endmodule // rlam_rx_front

// [hdl/rlam_monitor.sv]
module rlam_monitor import rlam_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [RLAM_NCH-1:0] rxClk,
	input wire logic [RLAM_NCH-1:0] receiveLinePositive,
	input wire logic [RLAM_NCH-1:0] receiveLineNegative,
	input wire logic [RLAM_NCH-1:0] analogLoss,
	input wire logic [RLAM_AW-1:0] regAddr,
	input wire logic [RLAM_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [RLAM_DW-1:0] regRdData,
	output logic [RLAM_NCH-1:0] allOnesAlarm,
	output logic [RLAM_NCH-1:0] bipolarViolationFlag,
	output logic [RLAM_NCH-1:0] signalLossFlag
);

	// ****************************************
	// State types
	// ****************************************
	typedef struct packed {
		logic [12:0] winCnt;
		logic [3:0] aisZeros;
		logic all_ones_alarm;
		logic [7:0] zeroRun;
		logic lastPol;
		logic seenPulse;
		logic [7:0] pHist;
		logic [4:0] vHist;
		logic bipolar_violation_flag;
		logic signal_loss_flag;
		logic [7:0] clrCnt;
		logic [7:0] clrOnes;
		logic clrBad;
		logic [RLAM_DW-1:0] vCnt;
	} rlam_ch_s;

	typedef struct packed {
		rlam_ch_s [RLAM_NCH-1:0] ch;
		logic [RLAM_CTRL_W-1:0] ctrl;
		logic [RLAM_DW-1:0] rdData;
	} rlam_state_s;

	rlam_state_s state_r, state_nxt;

	logic [RLAM_NCH-1:0] bitStb;
	logic [RLAM_NCH-1:0] pulse;
	logic [RLAM_NCH-1:0] polPos;
	logic [RLAM_NCH-1:0] lossSync;

	// Counter register index for a channel
	function automatic logic [RLAM_AW-1:0] vcntOfs(input int c);
		vcntOfs = (c == 0) ? RLAM_OFS_VCNT0 : RLAM_OFS_VCNT1;
	endfunction

	// Saturating increment of an 8-bit count
	function automatic logic [7:0] satInc8(input logic [7:0] v);
		satInc8 = (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	// ****************************************
	// Per-channel input sampling
	// ****************************************
	// separate front ends
	for (genvar g = 0; g < RLAM_NCH; g++) begin : gCh
		logic [RLAM_SYN_W-1:0] synced;

		rlam_sync2 #(.W(RLAM_SYN_W)) uSync (
			.mclk(mclk),
			.rst_n(rst_n),
			.asyncIn({analogLoss[g], receiveLineNegative[g], receiveLinePositive[g], rxClk[g]}),
			.syncOut(synced)
		);

		rlam_rx_front uFront (
			.mclk(mclk),
			.rst_n(rst_n),
			.synced(synced),
			.bitStb(bitStb[g]),
			.pulse(pulse[g]),
			.polPos(polPos[g])
		);

		assign lossSync[g] = synced[RLAM_SYN_LOSS];
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic coderEn;
		logic exzEn;
		logic e1;
		logic rawVio;
		logic [7:0] runNxt;
		logic [7:0] newP;
		logic [4:0] newV;
		logic exzEv;
		logic [3:0] zerosNxt;
		logic [7:0] onesNxt;
		logic badNxt;
		logic cntInc;
		coderEn = 1'b0;
		exzEn = 1'b0;
		e1 = 1'b0;
		rawVio = 1'b0;
		runNxt = '0;
		newP = '0;
		newV = '0;
		exzEv = 1'b0;
		zerosNxt = '0;
		onesNxt = '0;
		badNxt = 1'b0;
		cntInc = 1'b0;
		state_nxt = state_r;
		e1 = state_r.ctrl[RLAM_CTRL_E1];

		// Register writes
		if (regWr && regAddr == RLAM_OFS_CTRL) begin
			state_nxt.ctrl = regWrData[RLAM_CTRL_W-1:0];
		end

		// Register reads, data valid the next cycle
		state_nxt.rdData = '0;
		if (regRd) begin
			case (regAddr)
				RLAM_OFS_CTRL: state_nxt.rdData = RLAM_DW'(state_r.ctrl);
				RLAM_OFS_STATUS: begin
					for (int c = 0; c < RLAM_NCH; c++) begin
						state_nxt.rdData[RLAM_STAT_AIS + c] = state_r.ch[c].all_ones_alarm;
						state_nxt.rdData[RLAM_STAT_LOS + c] = state_r.ch[c].signal_loss_flag;
						state_nxt.rdData[RLAM_STAT_ANALOG + c] = lossSync[c];
					end
				end
				RLAM_OFS_VCNT0: state_nxt.rdData = state_r.ch[0].vCnt;
				RLAM_OFS_VCNT1: state_nxt.rdData = state_r.ch[1].vCnt;
				default: state_nxt.rdData = '0;
			endcase
		end

		for (int c = 0; c < RLAM_NCH; c++) begin
			coderEn = state_r.ctrl[RLAM_CTRL_CODER + c];
			exzEn = state_r.ctrl[RLAM_CTRL_EXZ + c];
			cntInc = 1'b0;

			if (lossSync[c]) begin
				state_nxt.ch[c].signal_loss_flag = 1'b1;
			end

			if (bitStb[c]) begin
				rawVio = pulse[c] & state_r.ch[c].seenPulse & (polPos[c] == state_r.ch[c].lastPol);
				if (coderEn && e1 && state_r.ch[c].zeroRun >= RLAM_HDB3_RUN) begin
					rawVio = 1'b0;
				end
				if (pulse[c]) begin
					state_nxt.ch[c].lastPol = polPos[c];
					state_nxt.ch[c].seenPulse = 1'b1;
				end
				newP = {state_r.ch[c].pHist[6:0], pulse[c]};
				newV = {state_r.ch[c].vHist[3:0], rawVio};
				// B8ZS pattern hides its two violations
				if (coderEn && !e1 && newP == RLAM_B8ZS_PULSES && newV[RLAM_B8ZS_V1] && newV[RLAM_B8ZS_V2]) begin
					newV[RLAM_B8ZS_V1] = 1'b0;
					newV[RLAM_B8ZS_V2] = 1'b0;
				end
				state_nxt.ch[c].pHist = newP;
				state_nxt.ch[c].vHist = newV;

				runNxt = pulse[c] ? 8'h00 : satInc8(state_r.ch[c].zeroRun);
				state_nxt.ch[c].zeroRun = runNxt;

				// threshold by coding mode, once per run
				exzEv = exzEn && !e1 && !pulse[c] && runNxt == (coderEn ? RLAM_EXZ_B8ZS : RLAM_EXZ_AMI);

				// flag held for one received bit
				state_nxt.ch[c].bipolar_violation_flag = newV[RLAM_B8ZS_V2] | exzEv;
				cntInc = newV[RLAM_B8ZS_V2] | exzEv;

				state_nxt.ch[c].winCnt = state_r.ch[c].winCnt + 13'h0001;
				zerosNxt = state_r.ch[c].aisZeros;
				if (!pulse[c] && zerosNxt != RLAM_AIS_ZEROS) begin
					zerosNxt = zerosNxt + 4'h1;
				end
				state_nxt.ch[c].aisZeros = zerosNxt;
				if (state_r.ch[c].winCnt == RLAM_AIS_LAST) begin
					state_nxt.ch[c].all_ones_alarm = (zerosNxt < RLAM_AIS_ZEROS);
					state_nxt.ch[c].aisZeros = '0;
				end

				if (runNxt >= RLAM_LOS_SET_RUN) begin
					state_nxt.ch[c].signal_loss_flag = 1'b1;
				end

				onesNxt = pulse[c] ? satInc8(state_r.ch[c].clrOnes) : state_r.ch[c].clrOnes;
				badNxt = state_r.ch[c].clrBad | (runNxt > RLAM_LOS_MAX_RUN);
				state_nxt.ch[c].clrCnt = state_r.ch[c].clrCnt + 8'h01;
				state_nxt.ch[c].clrOnes = onesNxt;
				state_nxt.ch[c].clrBad = badNxt;
				if (state_r.ch[c].clrCnt == RLAM_LOS_CLR_LAST) begin
					if (state_r.ch[c].signal_loss_flag && onesNxt >= RLAM_LOS_CLR_ONES && !badNxt && !lossSync[c]
						&& runNxt < RLAM_LOS_SET_RUN) begin
						state_nxt.ch[c].signal_loss_flag = 1'b0;
					end
					state_nxt.ch[c].clrCnt = '0;
					state_nxt.ch[c].clrOnes = '0;
					state_nxt.ch[c].clrBad = 1'b0;
				end
			end

			// Violation count, clear on read, increment wins
			if (regRd && regAddr == vcntOfs(c)) begin
				state_nxt.ch[c].vCnt = cntInc ? RLAM_DW'(1) : '0;
			end else if (cntInc && state_r.ch[c].vCnt != '1) begin
				state_nxt.ch[c].vCnt = state_r.ch[c].vCnt + RLAM_DW'(1);
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
			state_r.ctrl <= RLAM_CTRL_RST;
			for (int c = 0; c < RLAM_NCH; c++) begin
				state_r.ch[c].signal_loss_flag <= 1'b1;
			end
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from flops
	always_comb begin
		for (int c = 0; c < RLAM_NCH; c++) begin
			allOnesAlarm[c] = state_r.ch[c].all_ones_alarm;
			bipolarViolationFlag[c] = state_r.ch[c].bipolar_violation_flag;
			signalLossFlag[c] = state_r.ch[c].signal_loss_flag;
		end
	end

	assign regRdData = state_r.rdData;

endmodule // rlam_monitor

// [verification/rlam_monitor_asserts.sv]
module rlam_monitor_chk import rlam_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [RLAM_NCH-1:0] analogLoss,
	input wire logic [RLAM_AW-1:0] regAddr,
	input wire logic [RLAM_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [RLAM_DW-1:0] regRdData,
	input wire logic [RLAM_NCH-1:0] allOnesAlarm,
	input wire logic [RLAM_NCH-1:0] bipolarViolationFlag,
	input wire logic [RLAM_NCH-1:0] signalLossFlag
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Control shadow
	// ********
	logic [RLAM_CTRL_W-1:0] ctrlCopy_r;
	// Follows writes to the control word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlCopy_r <= RLAM_CTRL_RST;
		end else if (regWr && regAddr == RLAM_OFS_CTRL) begin
			ctrlCopy_r <= regWrData[RLAM_CTRL_W-1:0];
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Flags, read port and alarms
	property p_rstState;
		$rose(rst_n) |-> signalLossFlag == 2'h3 && allOnesAlarm == 2'h0;
	endproperty
	a_rstState: assert property (p_rstState) else $error("state after reset wrong");
	property p_analog0;
		analogLoss[0] [*4] |-> signalLossFlag[0];
	endproperty
	a_analog0: assert property (p_analog0) else $error("loss flag 0 not set");
	property p_analog1;
		analogLoss[1] [*4] |-> signalLossFlag[1];
	endproperty
	a_analog1: assert property (p_analog1) else $error("loss flag 1 not set");
	property p_aisSteady;
		$changed(allOnesAlarm[1]) |=> $stable(allOnesAlarm[1]) [*8];
	endproperty
	a_aisSteady: assert property (p_aisSteady) else $error("alarm toggles inside window");
	property p_bpvPulse;
		$rose(bipolarViolationFlag[0]) |=> bipolarViolationFlag[0] ##[1:40] !bipolarViolationFlag[0];
	endproperty
	a_bpvPulse: assert property (p_bpvPulse) else $error("violation pulse length wrong");
	property p_rdIdle;
		!$past(regRd) |-> regRdData == 16'h0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	property p_ctrlRead;
		$past(regRd) && $past(regAddr) == RLAM_OFS_CTRL |-> regRdData == RLAM_DW'($past(ctrlCopy_r));
	endproperty
	a_ctrlRead: assert property (p_ctrlRead) else $error("control readback wrong");
	property p_statRead;
		$past(regRd) && $past(regAddr) == RLAM_OFS_STATUS
			|-> regRdData[3:0] == {$past(signalLossFlag), $past(allOnesAlarm)};
	endproperty
	a_statRead: assert property (p_statRead) else $error("status readback wrong");
	// Main scenarios
	c_bpv: cover property ($rose(bipolarViolationFlag[0]));
	c_losClr: cover property ($fell(signalLossFlag[0]));
	c_ais: cover property ($rose(allOnesAlarm[1]));
endmodule // rlam_monitor_chk

// [verification/rlam_line_model.sv]
module rlam_line_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mark,
	input wire logic viol,
	output logic rxClk,
	output logic linePos,
	output logic lineNeg,
	output logic bitDone
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] phase_r;
	logic last_r;
	// Bit clock of six cycles, three high
	assign rxClk = phase_r < 3'h3;
	assign bitDone = phase_r == 3'h3;
	// Loads the next bit after the falling edge; marks alternate unless forced
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 3'h0;
			last_r <= 1'b0;
			linePos <= 1'b0;
			lineNeg <= 1'b0;
		end else begin
			phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
			if (bitDone) begin
				linePos <= mark & (viol ? last_r : ~last_r);
				lineNeg <= mark & (viol ? ~last_r : last_r);
				if (mark) begin
					last_r <= viol ? last_r : ~last_r;
				end
			end
		end
	end
endmodule // rlam_line_model

// [verification/rlam_monitor_tb_top.sv]
module rlam_monitor_tb_top import rlam_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] ctrl; int zeros; logic [7:0] pm; logic [7:0] pv; logic [15:0] cnt;} rlam_row_s;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic mark, viol, regWr, regRd;
	logic [RLAM_NCH-1:0] rxClk, pos, neg, bitDone, analogLoss, all_ones_alarm, bipolar_violation_flag, signal_loss_flag;
	logic [RLAM_AW-1:0] regAddr;
	logic [RLAM_DW-1:0] regWrData, regRdData, rdVal;
	int mismatches, checks;
	// Cases: control, zero run, pattern marks, forced violations, expected violation count
	rlam_row_s rows [10] = '{'{16'hFFE4, 15, 8'hFF, 8'h00, 16'h0000}, '{16'h0004, 16, 8'hFF, 8'h00, 16'h0001},
		'{16'h0005, 7, 8'hFF, 8'h00, 16'h0000}, '{16'hFFE5, 8, 8'hFF, 8'h00, 16'h0001},
		'{16'h0014, 16, 8'hFF, 8'h00, 16'h0000}, '{16'h000A, 16, 8'hFF, 8'h00, 16'h0000},
		'{16'h0000, 0, 8'h1B, 8'h12, 16'h0002}, '{16'h0001, 0, 8'h1B, 8'h12, 16'h0000},
		'{16'h0010, 0, 8'h10, 8'h10, 16'h0001}, '{16'h0011, 0, 8'h10, 8'h10, 16'h0000}};
	// ********
	// Clock, line models, design
	// ********
	initial forever #4 mclk = ~mclk;
	rlam_line_model ch0 (.mclk(mclk), .rst_n(rst_n), .mark(mark), .viol(viol), .rxClk(rxClk[0]),
		.linePos(pos[0]), .lineNeg(neg[0]), .bitDone(bitDone[0]));
	rlam_line_model ch1 (.mclk(mclk), .rst_n(rst_n), .mark(1'b1), .viol(1'b0), .rxClk(rxClk[1]),
		.linePos(pos[1]), .lineNeg(neg[1]), .bitDone(bitDone[1]));
	rlam_monitor uut (.mclk(mclk), .rst_n(rst_n), .rxClk(rxClk), .receiveLinePositive(pos),
		.receiveLineNegative(neg), .analogLoss(analogLoss), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .allOnesAlarm(all_ones_alarm),
		.bipolarViolationFlag(bipolar_violation_flag), .signalLossFlag(signal_loss_flag));
	// ********
	// Tasks
	// ********
	task automatic close_out();
		if (mismatches == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpFlag(input logic [1:0] got, input logic [1:0] exp);
		cmp({14'h0000, got}, {14'h0000, exp});
	endtask
	task automatic wr(input logic [RLAM_AW-1:0] a, input logic [RLAM_DW-1:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [RLAM_AW-1:0] a, output logic [RLAM_DW-1:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdData;
		@(posedge mclk);
	endtask
	// Hands n bits to channel 0, one per model load
	task automatic send(input int n, input logic m, input logic v);
		repeat (n) begin
			mark <= m;
			viol <= v;
			do @(negedge mclk); while (bitDone[0] !== 1'b1);
			@(posedge mclk);
		end
	endtask
	// ********
	// Tests
	// ********
	initial begin
		mark = 1'b1;
		viol = 1'b0;
		analogLoss = 2'h0;
		regAddr = 2'h0;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		mismatches = 0;
		checks = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// Table of coding modes and zero runs
		foreach (rows[i]) begin
			wr(RLAM_OFS_CTRL, rows[i].ctrl);
			rd(RLAM_OFS_CTRL, rdVal);
			cmp(rdVal, RLAM_DW'(rows[i].ctrl[RLAM_CTRL_W-1:0]));
			rd(RLAM_OFS_VCNT0, rdVal);
			for (int b = 7; b >= 0; b--) send(1, rows[i].pm[b], rows[i].pv[b]);
			send(rows[i].zeros, 1'b0, 1'b0);
			send(8, 1'b1, 1'b0);
			rd(RLAM_OFS_VCNT0, rdVal);
			cmp(rdVal, rows[i].cnt);
		end
		// Writes elsewhere leave control alone
		wr(RLAM_OFS_STATUS, 16'hFFFF);
		wr(RLAM_OFS_VCNT1, 16'hFFFF);
		rd(RLAM_OFS_CTRL, rdVal);
		cmp(rdVal, 16'h0011);
		wr(RLAM_OFS_CTRL, 16'h0000);
		cmpFlag(signal_loss_flag, 2'h0);
		// Zero runs below and above the loss tolerance
		send(159, 1'b0, 1'b0);
		send(1, 1'b1, 1'b0);
		repeat (10) @(posedge mclk);
		cmpFlag(signal_loss_flag, 2'h0);
		send(191, 1'b0, 1'b0);
		send(1, 1'b1, 1'b0);
		repeat (10) @(posedge mclk);
		cmpFlag(signal_loss_flag, 2'h1);
		send(430, 1'b1, 1'b0);
		cmpFlag(signal_loss_flag, 2'h0);
		// Analogue level loss on both channels
		analogLoss <= 2'h3;
		repeat (8) @(posedge mclk);
		cmpFlag(signal_loss_flag, 2'h3);
		rd(RLAM_OFS_STATUS, rdVal);
		cmp(rdVal, 16'h003C);
		analogLoss <= 2'h0;
		// All-ones channel 1 against channel 0 with zeros
		for (int k = 0; k < 60000 && all_ones_alarm[1] !== 1'b1; k++) @(posedge mclk);
		repeat (2) @(posedge mclk);
		cmpFlag(all_ones_alarm, 2'h2);
		// Reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		cmpFlag(signal_loss_flag, 2'h3);
		cmpFlag(all_ones_alarm | bipolar_violation_flag, 2'h0);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(RLAM_OFS_CTRL, rdVal);
		cmp(rdVal, 16'h0000);
		close_out();
	end
	// Watchdog beyond the expected run
	initial begin
		repeat (80000) @(posedge mclk);
		mismatches++;
		close_out();
	end
endmodule // rlam_monitor_tb_top
bind rlam_monitor rlam_monitor_chk chk (.mclk(mclk), .rst_n(rst_n), .analogLoss(analogLoss),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.allOnesAlarm(allOnesAlarm), .bipolarViolationFlag(bipolarViolationFlag), .signalLossFlag(signalLossFlag));
